//--- hw/ead_decoder.sv
// effective address mode decoder for the bytes after a primary opcode
// assumes the fetch path presents bytes with a one-cycle valid strobe
`default_nettype none
module ead_decoder (
	input  wire logic                CLK,
	input  wire logic                RSTN,
	input  wire logic                DEC_VALID,
	input  wire logic                FIXED_MODE,
	input  wire logic                MID_IS_REG,
	input  wire logic                DEFAULT_ADDR32,
	input  wire logic                ADDR_PREFIX,
	input  wire logic                OP32,
	input  wire logic                WIDTH_BIT,
	input  wire logic [7:0]          MODE_BYTE,
	input  wire logic [7:0]          SIB_BYTE,
	input  wire logic [31:0]         DISP_BYTES,
	output logic                     OUT_VALID,
	output logic                     IS_REG,
	output logic      [2:0]          REG_NUM,
	output logic                     REG_HIGH,
	output logic      [1:0]          REG_SIZE,
	output logic                     MID_REG_VALID,
	output logic      [2:0]          MID_FIELD,
	output logic                     ADDR32,
	output logic                     BASE_VALID,
	output logic      [2:0]          BASE_REG,
	output logic                     INDEX_VALID,
	output logic      [2:0]          INDEX_REG,
	output logic      [1:0]          SCALE_SHIFT,
	output ead_pkg::ead_seg_e        SEGMENT,
	output logic      [2:0]          DISP_LEN,
	output logic      [31:0]         DISPLACEMENT,
	output logic      [2:0]          ADDR_BYTES_LEN
);
	import ead_pkg::*;

	// fields of the mode and index bytes
	logic [1:0] kind;
	logic [2:0] loc;
	logic [2:0] mid;
	logic [1:0] ss;
	logic [2:0] idx;
	logic [2:0] sbase;
	logic       addr32_eff;
	logic       has_sib;

	// recipe under construction: form, base, index, scale, segment and displacement length
	logic       next_is_reg;
	logic       next_base_valid;
	logic [2:0] next_base;
	logic       next_index_valid;
	logic [2:0] next_index;
	logic [1:0] next_scale;
	ead_seg_e   next_seg;
	logic [2:0] next_disp_len;

	// register-form and displacement paths
	logic [2:0] rs_num;
	logic       rs_high;
	logic [1:0] rs_size;
	logic [31:0] disp_ext;

	// displacement bytes that a kind code carries at the given address size
	function automatic logic [2:0] disp_size_f(input logic [1:0] k, input logic wide);
		unique case (k)
			KIND_SHORT: disp_size_f = DISP_1;
			KIND_LONG:  disp_size_f = wide ? DISP_4 : DISP_2;
			default:    disp_size_f = DISP_0;
		endcase
	endfunction : disp_size_f

	// field extraction from the mode and index bytes
	assign kind  = MODE_BYTE[MODE_KIND_HI:MODE_KIND_LO];
	assign mid   = MODE_BYTE[MODE_MID_HI:MODE_MID_LO];
	assign loc   = MODE_BYTE[MODE_LOC_HI:MODE_LOC_LO];
	assign ss    = SIB_BYTE[MODE_KIND_HI:MODE_KIND_LO];
	assign idx   = SIB_BYTE[MODE_MID_HI:MODE_MID_LO];
	assign sbase = SIB_BYTE[MODE_LOC_HI:MODE_LOC_LO];

	assign addr32_eff = DEFAULT_ADDR32 ^ ADDR_PREFIX;

	assign has_sib = addr32_eff && (loc == LOC_SIB) && (kind != KIND_REG);

	// register operand decode
	ead_regsel u_regsel (
		.code      (loc),
		.width_bit (WIDTH_BIT),
		.op32      (OP32),
		.reg_num   (rs_num),
		.reg_high  (rs_high),
		.reg_size  (rs_size)
	);

	// address recipe decode
	always_comb begin
		next_is_reg      = 1'b0;
		next_base_valid  = 1'b0;
		next_base        = loc;
		next_index_valid = 1'b0;
		next_index       = 3'h0;
		next_scale       = 2'h0;
		next_seg         = EAD_SEG_DATA;
		next_disp_len    = DISP_0;
		if (kind == KIND_REG) begin
			next_is_reg = 1'b1;
		end else if (!addr32_eff) begin
			next_base_valid  = 1'b1;
			next_index_valid = !loc[2];
			next_index       = loc[0] ? GP7 : GP6;
			unique case (loc)
				3'h0, 3'h1: next_base = GP3;
				3'h2, 3'h3: next_base = GP5;
				3'h4:       next_base = GP6;
				3'h5:       next_base = GP7;
				3'h6:       next_base = GP5;
				3'h7:       next_base = GP3;
			endcase
			if (loc[2:1] == 2'h1 || loc == 3'h6) begin
				next_seg = EAD_SEG_STACK;
			end
			if (loc >= 3'h4) begin
				next_index_valid = 1'b0;
			end
			next_disp_len = disp_size_f(kind, 1'b0);
			// 00 110 is the one 16-bit direct form, always in the data segment
			if (kind == KIND_NONE && loc == LOC_DIRECT16) begin
				next_base_valid = 1'b0;
				next_seg        = EAD_SEG_DATA;
				next_disp_len   = DISP_2;
			end
		end else begin
			// 32-bit displacement kinds
			// a locator of 100 never takes the plain path: it brings an index byte
			next_disp_len = disp_size_f(kind, 1'b1);
			if (has_sib) begin
				next_index_valid = (idx != IDX_NONE);
				next_index       = idx;
				next_scale       = (idx != IDX_NONE) ? ss : 2'h0;
				next_base        = sbase;
				next_base_valid  = 1'b1;
				if (sbase == 3'h4) begin
					next_seg = EAD_SEG_STACK;
				end else if (sbase == LOC_DIRECT32) begin
					if (kind == KIND_NONE) begin
						next_base_valid = 1'b0;
						next_disp_len   = DISP_4;
					end else begin
						next_seg = EAD_SEG_STACK;
					end
				end
			end else begin
				next_base_valid = 1'b1;
				if (loc == LOC_DIRECT32) begin
					if (kind == KIND_NONE) begin
						next_base_valid = 1'b0;
						next_disp_len   = DISP_4;
					end else begin
						next_seg = EAD_SEG_STACK;
					end
				end
			end
		end
	end

	ead_sext u_sext (
		.disp_bytes (DISP_BYTES),
		.disp_len   (next_disp_len),
		.addr32     (addr32_eff),
		.disp       (disp_ext)
	);

	// answer valid one cycle after the request
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			OUT_VALID <= 1'b0;
		end else begin
			OUT_VALID <= DEC_VALID;
		end
	end

	// register operand outputs, loaded on each request
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			IS_REG   <= 1'b0;
			REG_NUM  <= 3'h0;
			REG_HIGH <= 1'b0;
			REG_SIZE <= 2'h0;
		end else if (DEC_VALID) begin
			// fixed-mode instructions carry no operand form
			IS_REG   <= next_is_reg && !FIXED_MODE;
			REG_NUM  <= rs_num;
			REG_HIGH <= rs_high;
			REG_SIZE <= rs_size;
		end
	end

	// address recipe registers: size, base, index, scale and segment
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ADDR32      <= 1'b0;
			BASE_VALID  <= 1'b0;
			BASE_REG    <= 3'h0;
			INDEX_VALID <= 1'b0;
			INDEX_REG   <= 3'h0;
			SCALE_SHIFT <= 2'h0;
			SEGMENT     <= EAD_SEG_DATA;
		end else if (DEC_VALID) begin
			ADDR32 <= addr32_eff;
			if (FIXED_MODE) begin
				BASE_VALID  <= 1'b0;
				INDEX_VALID <= 1'b0;
				SCALE_SHIFT <= 2'h0;
				SEGMENT     <= EAD_SEG_DATA;
			end else begin
				BASE_VALID  <= next_base_valid && !next_is_reg;
				BASE_REG    <= next_base;
				INDEX_VALID <= next_index_valid && !next_is_reg;
				INDEX_REG   <= next_index;
				SCALE_SHIFT <= next_scale;
				SEGMENT     <= next_seg;
			end
		end
	end

	// displacement registers, cleared for register and fixed forms
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			DISP_LEN     <= DISP_0;
			DISPLACEMENT <= DISP_RESET;
		end else if (DEC_VALID) begin
			if (FIXED_MODE || next_is_reg) begin
				DISP_LEN     <= DISP_0;
				DISPLACEMENT <= DISP_RESET;
			end else begin
				DISP_LEN     <= next_disp_len;
				DISPLACEMENT <= disp_ext;
			end
		end
	end

	// middle field as register or extension
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			MID_REG_VALID <= 1'b0;
			MID_FIELD     <= 3'h0;
		end else if (DEC_VALID) begin
			MID_REG_VALID <= MID_IS_REG && !FIXED_MODE;
			MID_FIELD     <= mid;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			ADDR_BYTES_LEN <= 3'h0;
		end else if (DEC_VALID) begin
			if (FIXED_MODE) begin
				ADDR_BYTES_LEN <= 3'h0;
			end else if (next_is_reg) begin
				ADDR_BYTES_LEN <= 3'h1;
			end else begin
				// mode byte, optional index byte, then the displacement
				ADDR_BYTES_LEN <= 3'(next_disp_len + (has_sib ? 3'h2 : 3'h1));
			end
		end
	end
endmodule : ead_decoder
`default_nettype wire

//--- hw/ead_pkg.sv
// effective address decoder package: field positions, codes, sizes
// assumes a single core clock domain and synchronous reset
`default_nettype none
package ead_pkg;
	// mode byte and scale-index-base byte field positions
	localparam int MODE_KIND_HI   = 7;
	localparam int MODE_KIND_LO   = 6;
	localparam int MODE_MID_HI    = 5;
	localparam int MODE_MID_LO    = 3;
	localparam int MODE_LOC_HI    = 2;
	localparam int MODE_LOC_LO    = 0;
	// displacement-kind codes
	localparam logic [1:0] KIND_NONE  = 2'h0;
	localparam logic [1:0] KIND_SHORT = 2'h1;
	localparam logic [1:0] KIND_LONG  = 2'h2;
	localparam logic [1:0] KIND_REG   = 2'h3;
	// special locator codes
	localparam logic [2:0] LOC_SIB      = 3'h4;
	localparam logic [2:0] LOC_DIRECT32 = 3'h5;
	localparam logic [2:0] LOC_DIRECT16 = 3'h6;
	localparam logic [2:0] IDX_NONE     = 3'h4;
	// register numbers
	localparam logic [2:0] GP3 = 3'h3;
	localparam logic [2:0] GP5 = 3'h5;
	localparam logic [2:0] GP6 = 3'h6;
	localparam logic [2:0] GP7 = 3'h7;
	// segment codes
	typedef enum logic [1:0] {
		EAD_SEG_DATA  = 2'b00,
		EAD_SEG_STACK = 2'b01
	} ead_seg_e;
	// displacement size codes, in bytes
	localparam logic [2:0] DISP_0 = 3'h0;
	localparam logic [2:0] DISP_1 = 3'h1;
	localparam logic [2:0] DISP_2 = 3'h2;
	localparam logic [2:0] DISP_4 = 3'h4;
	// reset values of the answer
	localparam logic [31:0] DISP_RESET = 32'h0000_0000;
endpackage : ead_pkg
`default_nettype wire

//--- hw/ead_regsel.sv
// register-operand selector for the register form of the mode byte
// assumes width bit and operation size are valid with the mode byte
`default_nettype none
module ead_regsel (
	input  wire logic [2:0] code,
	input  wire logic       width_bit,
	input  wire logic       op32,
	output logic      [2:0] reg_num,
	output logic            reg_high,
	output logic      [1:0] reg_size
);
	// byte form maps codes 4..7 to the high bytes of gp0..gp3
	always_comb begin
		if (!width_bit) begin
			reg_num  = {1'b0, code[1:0]};
			reg_high = code[2];
			reg_size = 2'h0;
		end else begin
			reg_num  = code;
			reg_high = 1'b0;
			reg_size = op32 ? 2'h2 : 2'h1;
		end
	end
endmodule : ead_regsel
`default_nettype wire

//--- hw/ead_sext.sv
// displacement assembler: little-endian bytes, short form sign-extended
// assumes byte 0 of disp_bytes is the first byte after the addressing bytes
`default_nettype none
module ead_sext (
	input  wire logic [31:0] disp_bytes,
	input  wire logic [2:0]  disp_len,
	input  wire logic        addr32,
	output logic      [31:0] disp
);
	import ead_pkg::*;
	// pick and extend the displacement to the address width
	always_comb begin
		unique case (disp_len)
			DISP_1: begin
				disp = {{24{disp_bytes[7]}}, disp_bytes[7:0]};
				if (!addr32) begin
					disp[31:16] = 16'h0000;
				end
			end
			DISP_2:  disp = {16'h0000, disp_bytes[15:0]};
			DISP_4:  disp = disp_bytes;
			default: disp = 32'h0000_0000;
		endcase
	end
endmodule : ead_sext
`default_nettype wire

//--- verification/ead_agen_model.sv
// address-generation side model: takes each answer in its strobe cycle
// assumes the answer strobe is one cycle wide and reset is synchronous
`default_nettype none
module ead_agen_model (
	input  wire logic        CLK,
	input  wire logic        RSTN,
	input  wire logic        OUT_VALID,
	output logic      [15:0] n_taken
);
	timeunit 1ns;
	timeprecision 1ns;
	// count answers, one per strobe cycle
	always_ff @(posedge CLK) begin
		if (!RSTN) begin
			n_taken <= 16'h0;
		end else if (OUT_VALID) begin
			n_taken <= n_taken + 16'h1;
		end
	end
endmodule : ead_agen_model
`default_nettype wire

//--- verification/ead_decoder_props.sv
// port checker for the decoder: latency, forms, sizes
// assumes one clock and a synchronous active-low reset
`default_nettype none
module ead_decoder_props (
	input wire logic              CLK,
	input wire logic              RSTN,
	input wire logic              DEC_VALID,
	input wire logic              FIXED_MODE,
	input wire logic              DEFAULT_ADDR32,
	input wire logic              ADDR_PREFIX,
	input wire logic [7:0]        MODE_BYTE,
	input wire logic [7:0]        SIB_BYTE,
	input wire logic              OUT_VALID,
	input wire logic              IS_REG,
	input wire logic [2:0]        MID_FIELD,
	input wire logic              ADDR32,
	input wire logic              BASE_VALID,
	input wire logic              INDEX_VALID,
	input wire logic [1:0]        SCALE_SHIFT,
	input wire ead_pkg::ead_seg_e SEGMENT,
	input wire logic [2:0]        DISP_LEN,
	input wire logic [2:0]        ADDR_BYTES_LEN
);
	import ead_pkg::*;
	// request qualifiers
	wire logic go = DEC_VALID && !FIXED_MODE;
	wire logic a32 = DEFAULT_ADDR32 ^ ADDR_PREFIX;
	wire logic sib = go && a32 && MODE_BYTE[7:6] != KIND_REG && MODE_BYTE[2:0] == LOC_SIB;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RSTN);
	answer_latency_a: assert property (DEC_VALID |=> OUT_VALID)
		else $error("answer strobe missing");
	idle_quiet_a: assert property (!DEC_VALID |=> !OUT_VALID)
		else $error("answer strobe without request");
	fixed_len_a: assert property (DEC_VALID && FIXED_MODE |=> ADDR_BYTES_LEN == 3'h0)
		else $error("fixed mode length");
	mid_field_a: assert property (go |=> MID_FIELD == $past(MODE_BYTE[5:3]))
		else $error("middle field");
	addr_size_a: assert property (go |=> ADDR32 == $past(a32))
		else $error("address size");
	reg_form_a: assert property (go && MODE_BYTE[7:6] == KIND_REG
		|=> IS_REG && !BASE_VALID && DISP_LEN == DISP_0 && ADDR_BYTES_LEN == 3'h1) else $error("reg form");
	sib_len_a: assert property (sib |=> ADDR_BYTES_LEN == DISP_LEN + 3'h2)
		else $error("index byte length");
	no_index_a: assert property (sib && SIB_BYTE[5:3] == IDX_NONE
		|=> !INDEX_VALID && SCALE_SHIFT == 2'h0) else $error("no index");
	direct16_a: assert property (go && !a32 && MODE_BYTE[7:6] == KIND_NONE
		&& MODE_BYTE[2:0] == LOC_DIRECT16 |=> !BASE_VALID && DISP_LEN == DISP_2
		&& SEGMENT == EAD_SEG_DATA) else $error("direct 16");
	scale_pass_a: assert property (sib && SIB_BYTE[5:3] != IDX_NONE
		|=> INDEX_VALID && SCALE_SHIFT == $past(SIB_BYTE[7:6])) else $error("scale field");
	stack_base_a: assert property (sib && SIB_BYTE[2:0] == 3'h4
		|=> BASE_VALID && SEGMENT == EAD_SEG_STACK) else $error("stack base");
	bp16_stack_a: assert property (go && !a32 && MODE_BYTE[7:6] != KIND_REG
		&& MODE_BYTE[2:1] == 2'h1 |=> SEGMENT == EAD_SEG_STACK && INDEX_VALID)
		else $error("16-bit stack pair");
endmodule : ead_decoder_props
bind ead_decoder ead_decoder_props ead_decoder_props_inst (.CLK, .RSTN, .DEC_VALID, .FIXED_MODE,
	.DEFAULT_ADDR32, .ADDR_PREFIX, .MODE_BYTE, .SIB_BYTE, .OUT_VALID, .IS_REG, .MID_FIELD,
	.ADDR32, .BASE_VALID, .INDEX_VALID, .SCALE_SHIFT, .SEGMENT, .DISP_LEN, .ADDR_BYTES_LEN);
`default_nettype wire

//--- verification/tb.sv
// testbench for the decoder: all mode bytes, random traffic, mid-run reset
// assumes the decoder answers one cycle after each taken request
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	import ead_pkg::*;
	logic clk = 0, rstn = 0, dv = 0, fix = 0, mir = 0, def = 0, pre = 0, op = 0, wb = 0;
	logic [7:0] mb = 0, sb = 0;
	logic [31:0] db = 0, dsp;
	logic ov, isr, rh, mrv, a32o, bv, iv, pv = 0, pfix, pw, pop, pa, pmir, use_sfix = 0;
	logic [2:0] rn, mf, br, ir, dl, al;
	logic [1:0] rs, ss;
	ead_seg_e seg;
	logic [15:0] taken;
	logic [7:0] pm, ps, sfix = 0;
	logic [31:0] pd;
	int n_errors = 0, n_compared = 0, reqs = 0, seed = 32'h0ca6;
	ead_decoder ead_decoder_inst (.CLK(clk), .RSTN(rstn), .DEC_VALID(dv), .FIXED_MODE(fix),
		.MID_IS_REG(mir), .DEFAULT_ADDR32(def), .ADDR_PREFIX(pre), .OP32(op), .WIDTH_BIT(wb),
		.MODE_BYTE(mb), .SIB_BYTE(sb), .DISP_BYTES(db), .OUT_VALID(ov), .IS_REG(isr),
		.REG_NUM(rn), .REG_HIGH(rh), .REG_SIZE(rs), .MID_REG_VALID(mrv), .MID_FIELD(mf),
		.ADDR32(a32o), .BASE_VALID(bv), .BASE_REG(br), .INDEX_VALID(iv), .INDEX_REG(ir),
		.SCALE_SHIFT(ss), .SEGMENT(seg), .DISP_LEN(dl), .DISPLACEMENT(dsp),
		.ADDR_BYTES_LEN(al));
	ead_agen_model ead_agen_model_inst (.CLK(clk), .RSTN(rstn), .OUT_VALID(ov), .n_taken(taken));
	// clock at 100 ns
	always #50 clk = ~clk;
	// expected memory recipe from the mode and index bytes
	function automatic logic [48:0] ref_f(input logic [7:0] m, s, input logic a, input logic [31:0] d);
		logic bvx, ivx, sg;
		logic [2:0] b, i, dlx, n;
		logic [1:0] sc;
		logic [31:0] x;
		bvx = 1; ivx = 0; i = 0; sc = 0; b = m[2:0]; n = 3'h1;
		dlx = m[7:6] == KIND_SHORT ? DISP_1 : m[7:6] == KIND_LONG ? (a ? DISP_4 : DISP_2) : DISP_0;
		if (!a) begin
			b = 3'(24'h77eb5b >> (m[2:0] * 3));
			ivx = !m[2];
			i = {2'h3, m[0]};
			if (m[7:6] == KIND_NONE && m[2:0] == LOC_DIRECT16) begin
				bvx = 0; dlx = DISP_2;
			end
		end else if (m[2:0] == LOC_SIB) begin
			n = 3'h2; b = s[2:0]; sc = s[7:6]; i = s[5:3]; ivx = i != IDX_NONE;
			if (m[7:6] == KIND_NONE && b == LOC_DIRECT32) begin
				bvx = 0; dlx = DISP_4;
			end
		end else if (m[7:6] == KIND_NONE && m[2:0] == LOC_DIRECT32) begin
			bvx = 0; dlx = DISP_4;
		end
		sg = bvx && (b == GP5 || (a && b == 3'h4));
		x = dlx == DISP_1 ? {{24{d[7]}}, d[7:0]} : dlx == DISP_2 ? {16'h0, d[15:0]} : dlx == DISP_4 ? d : 32'h0;
		if (!a) x[31:16] = 16'h0;
		return {bvx, bvx ? b : 3'h0, ivx, ivx ? i : 3'h0, ivx ? sc : 2'h0, sg, dlx, n + dlx, x};
	endfunction : ref_f
	task cmp(input logic [63:0] a, e);
		n_compared++;
		if (a !== e) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, a, e);
		end
	endtask : cmp
	task check;
		logic [48:0] act;
		act = {bv, bv ? br : 3'h0, iv, iv ? ir : 3'h0, ss, seg[0], dl, al, dl != 3'h0 ? dsp : 32'h0};
		cmp(64'(ov), 64'h1);
		cmp(64'({a32o, mrv, mf}), 64'({pa, pmir && !pfix, pm[5:3]}));
		if (pfix) cmp(64'(al), 64'h0);
		else if (pm[7:6] == KIND_REG) cmp(64'({isr, rn, rh, rs, al}), 64'({1'b1, pw ? pm[2:0] : {1'b0, pm[1:0]}, !pw && pm[2], pw ? (pop ? 2'h2 : 2'h1) : 2'h0, 3'h1}));
		else cmp(64'({isr, act}), 64'({1'b0, ref_f(pm, ps, pa, pd)}));
	endtask : check
	// check the previous answer, then present one request
	task step(input logic v, input logic [7:0] m, input logic f, d, p);
		if (pv) check();
		else cmp(64'(ov), 64'h0);
		ps = use_sfix ? sfix : 8'($random(seed));
		if (ps[5:3] == IDX_NONE) ps[7:6] = 2'h0;
		dv = v; mb = m; fix = f; def = d; pre = p; sb = ps; db = $random(seed);
		wb = 1'($random(seed)); op = 1'($random(seed)); mir = 1'($random(seed));
		pv = v; pm = m; pd = db; pfix = f; pa = d ^ p; pw = wb; pop = op; pmir = mir;
		if (v) reqs++;
		@(posedge clk);
		#1;
	endtask : step
	task summarize;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	initial begin
		repeat (3) @(posedge clk);
		#1 rstn = 1;
		for (int j = 0; j < 1024; j++) step(1'b1, j[7:0], 1'b0, j[8], j[9]);
		$display("all mode bytes done");
		// every index byte under kinds 00, 01 and 10 with 32-bit addressing, those with no index only with scale 00
		use_sfix = 1;
		for (int j = 0; j < 768; j++) begin
			sfix = j[7:0];
			step(1'b1, {j[9:8], 6'h04}, 1'b0, 1'b1, 1'b0);
		end
		use_sfix = 0;
		$display("index byte sweep done");
		for (int j = 0; j < 400; j++) begin
			step(1'($random(seed)), 8'($random(seed)), 3'($random(seed)) == 3'h0, 1'($random(seed)), 1'($random(seed)));
		end
		$display("random traffic done");
		rstn = 0; dv = 0; pv = 0; reqs = 0;
		@(posedge clk);
		#1 cmp(64'({ov, al, dl}), 64'h0);
		rstn = 1;
		step(1'b1, 8'h46, 1'b0, 1'b0, 1'b0);
		step(1'b0, 8'h00, 1'b0, 1'b0, 1'b0);
		cmp(64'(taken), 64'(reqs));
		$display("reset and count done");
		summarize();
	end
	// watchdog
	initial begin
		repeat (4000) @(posedge clk);
		n_errors++;
		summarize();
	end
endmodule : tb
`default_nettype wire
